//--- core/dispatch_cfg.svh
// Configuration constants for the dual dispatch and completion control.
// Assumes inclusion by the package and the design modules by bare name.
`ifndef DISPATCH_CFG_SVH
`define DISPATCH_CFG_SVH

`define UNIT_W 3
`define NUM_UNITS 8
`define RENAME_W 3
`define CQ_CNT_W 3
`define CQ_DEPTH 6
`define EXEC_LIMIT 5
`define EXEC_CNT_W 4
`define SER_CNT_W 8
`define CR_LIMIT 1
`define GPR_LIMIT 2
`define FPR_LIMIT 1
`define BRANCH_UNIT_CYCLES 1

`endif

//--- core/dispatch_pkg.sv
// Types shared by the dispatch and completion control and its branch check.
// Assumes dispatch_cfg.svh supplies the unit, rename and counter widths.
`include "dispatch_cfg.svh"

package dispatch_pkg;

  typedef enum logic [2:0] {
    BR_PLAIN = 3'h0,
    BR_TO_LINK = 3'h1,
    BR_TO_COUNT = 3'h2,
    BR_DEC_COND = 3'h3,
    BR_COND_ONLY = 3'h4
  } branch_kind_t;

  typedef struct packed {
    logic valid;
    branch_kind_t kind;
    logic saves_link;
    logic cond_true;
  } branch_t;

  typedef struct packed {
    logic valid;
    logic [`UNIT_W-1:0] unit;
    logic [`RENAME_W-1:0] gpr_need;
    logic [`RENAME_W-1:0] fpr_need;
    logic serial;
    logic arch64;
  } slot_t;

  typedef struct packed {
    logic valid;
    logic finished;
    logic after_unresolved;
    logic exception;
    logic int_or_load;
    logic cr_upd;
    logic [1:0] gpr_upd;
    logic fpr_upd;
  } centry_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_BUSY = 2'b10
  } ser_state_t;

  typedef struct packed {
    ser_state_t ser;
    logic [`EXEC_CNT_W-1:0] exec_count;
    logic [`SER_CNT_W-1:0] ser_cycles;
    logic illegal;
    logic branch_done;
    logic discard;
    logic take_exception;
  } ctrl_state_t;

endpackage

//--- core/branch_resolve.sv
// Branch resolution check: may the branch resolve this cycle without stall.
// Assumes register availability flags come from the rename logic.
`timescale 1ns/1ns
`include "dispatch_cfg.svh"

module branch_resolve
(
  input wire dispatch_pkg::branch_t branch,
  input wire logic link_ready,
  input wire logic count_ready,
  input wire logic shadow_free,
  input wire logic unresolved_pred,
  output logic resolve_ok
);
  import dispatch_pkg::*;

  logic kind_ok;

  always_comb
  begin
    case (branch.kind)
      BR_TO_LINK: kind_ok = link_ready;
      BR_TO_COUNT: kind_ok = count_ready;
      BR_DEC_COND: kind_ok = (count_ready | ~branch.cond_true) & ~unresolved_pred;
      BR_COND_ONLY: kind_ok = ~unresolved_pred;
      default: kind_ok = 1'b1;
    endcase
    resolve_ok = branch.valid & kind_ok & (~branch.saves_link | shadow_free);
  end

endmodule

//--- core/dispatch_completion_control.sv
// Dual dispatch, retirement and branch resolution control for the core.
// Assumes slot, queue and rename inputs are synchronous to clk.
`timescale 1ns/1ns
`include "dispatch_cfg.svh"

module dispatch_completion_control
#(
  parameter int CQ_DEPTH = `CQ_DEPTH,
  parameter int EXEC_LIMIT = `EXEC_LIMIT,
  parameter int NUM_UNITS = `NUM_UNITS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire dispatch_pkg::branch_t branch,
  input wire logic link_ready,
  input wire logic count_ready,
  input wire logic shadow_free,
  input wire logic unresolved_pred,
  input wire logic mispredict,
  input wire dispatch_pkg::slot_t lower_dispatch_slot,
  input wire dispatch_pkg::slot_t upper_dispatch_slot,
  input wire logic [NUM_UNITS-1:0] unit_free,
  input wire logic [`RENAME_W-1:0] gpr_free,
  input wire logic [`RENAME_W-1:0] fpr_free,
  input wire logic [`CQ_CNT_W-1:0] cq_count,
  input wire logic [1:0] exec_finish,
  input wire logic [`EXEC_CNT_W-1:0] squash_count,
  input wire logic ser_done,
  input wire dispatch_pkg::centry_t oldest_completion_entry,
  input wire dispatch_pkg::centry_t second_completion_entry,
  output logic branch_resolve_now,
  output logic branch_folded,
  output logic dispatch_lower,
  output logic dispatch_upper,
  output logic retire_oldest,
  output logic retire_second,
  output logic discard_younger,
  output logic illegal_instr,
  output logic take_exception,
  output logic serial_busy,
  output logic [`SER_CNT_W-1:0] serial_cycles,
  output logic [`EXEC_CNT_W-1:0] exec_count
);
  import dispatch_pkg::*;

  generate
    if (CQ_DEPTH < 2 || CQ_DEPTH >= (1 << `CQ_CNT_W))
    begin : g_bad_cq
      $error("CQ_DEPTH out of range");
    end
    if (EXEC_LIMIT < 2 || EXEC_LIMIT >= (1 << (`EXEC_CNT_W - 1)))
    begin : g_bad_exec
      $error("EXEC_LIMIT out of range");
    end
    if (NUM_UNITS > (1 << `UNIT_W) || NUM_UNITS < 2)
    begin : g_bad_units
      $error("NUM_UNITS out of range");
    end
    if (`BRANCH_UNIT_CYCLES != 1)
    begin : g_bad_fold
      $error("Fold logic assumes a one-cycle branch unit");
    end
    if (`CR_LIMIT > 2 || `GPR_LIMIT > 6 || `FPR_LIMIT > 2)
    begin : g_bad_pair
      $error("Paired update limits out of range");
    end
  endgenerate

  // Limits at counter width
  localparam logic [`CQ_CNT_W-1:0] CQ_MAX = `CQ_CNT_W'(CQ_DEPTH);
  localparam logic [`EXEC_CNT_W-1:0] EXEC_MAX = `EXEC_CNT_W'(EXEC_LIMIT);
  localparam logic [`SER_CNT_W-1:0] SER_SAT = {`SER_CNT_W{1'b1}};

  // Registered state and its next value
  ctrl_state_t state;
  ctrl_state_t next_state;

  logic resolve_ok;
  logic lower_ok;
  logic upper_ok;
  logic lower_unit;
  logic upper_unit;
  logic oldest_ok;
  logic second_ok;
  logic pair_ok;
  logic [`EXEC_CNT_W-1:0] issued;
  logic [`EXEC_CNT_W-1:0] drained;
  logic [`RENAME_W:0] gpr_sum;
  logic [`RENAME_W:0] fpr_sum;
  logic [NUM_UNITS-1:0] unit_left;
  logic [`EXEC_CNT_W:0] drain_sum;

  // True when the named unit is free
  function automatic logic unit_avail(input logic [NUM_UNITS-1:0] free, input logic [`UNIT_W-1:0] unit);
    unit_avail = (32'(unit) < NUM_UNITS) ? free[unit] : 1'b0;
  endfunction

  // True when the pool holds the need given
  function automatic logic pool_fits(input logic [`RENAME_W-1:0] free, input logic [`RENAME_W:0] need);
    pool_fits = ({1'b0, free} >= need);
  endfunction

  // Entry passes the common retire checks
  function automatic logic entry_ready(input centry_t e);
    entry_ready = e.valid & e.finished & ~e.after_unresolved & ~e.exception;
  endfunction

  // Paired updates stay within the limit
  function automatic logic pair_fits(input logic [1:0] a, input logic [1:0] b, input logic [2:0] limit);
    pair_fits = (({1'b0, a} + {1'b0, b}) <= limit);
  endfunction

  // Branch resolution conditions in their own block
  branch_resolve u_branch_resolve
  (
    .branch(branch),
    .link_ready(link_ready),
    .count_ready(count_ready),
    .shadow_free(shadow_free),
    .unresolved_pred(unresolved_pred),
    .resolve_ok(resolve_ok)
  );

  assign branch_resolve_now = resolve_ok;

  // Lower slot issue
  always_comb
  begin
    lower_unit = unit_avail(unit_free, lower_dispatch_slot.unit);
    lower_ok = lower_dispatch_slot.valid
      & ~lower_dispatch_slot.arch64
      & lower_unit
      & pool_fits(gpr_free, {1'b0, lower_dispatch_slot.gpr_need})
      & pool_fits(fpr_free, {1'b0, lower_dispatch_slot.fpr_need})
      & (cq_count < CQ_MAX)
      & (~lower_dispatch_slot.serial | (cq_count == '0))
      & (state.ser == SER_IDLE)
      & (state.exec_count < EXEC_MAX)
      & ~mispredict;
  end

  // Units still free once the lower slot has taken its own
  generate
    for (genvar u = 0; u < NUM_UNITS; u++)
    begin : g_unit_left
      assign unit_left[u] = unit_free[u] & ~(lower_ok & (lower_dispatch_slot.unit == `UNIT_W'(u)));
    end
  endgenerate

  // Upper slot issue, charged after the lower slot's share
  always_comb
  begin
    upper_unit = unit_avail(unit_left, upper_dispatch_slot.unit);
    // Both pools charged with the two shares summed
    gpr_sum = {1'b0, lower_dispatch_slot.gpr_need} + {1'b0, upper_dispatch_slot.gpr_need};
    fpr_sum = {1'b0, lower_dispatch_slot.fpr_need} + {1'b0, upper_dispatch_slot.fpr_need};
    upper_ok = lower_ok
      & ~lower_dispatch_slot.serial
      & upper_dispatch_slot.valid
      & ~upper_dispatch_slot.serial
      & ~upper_dispatch_slot.arch64
      & upper_unit
      & pool_fits(gpr_free, gpr_sum)
      & pool_fits(fpr_free, fpr_sum)
      & ({1'b0, cq_count} + {`CQ_CNT_W'(0), 1'b1} < {1'b0, CQ_MAX})
      & (state.exec_count + `EXEC_CNT_W'(1) < EXEC_MAX);
  end

  // Grants are combinational, seen by the far side this cycle
  assign dispatch_lower = lower_ok;
  assign dispatch_upper = upper_ok;

  // Retirement from the two oldest entries, oldest first
  always_comb
  begin
    // Mispredict holds retirement for its cycle
    oldest_ok = entry_ready(oldest_completion_entry) & ~mispredict;
    pair_ok = pair_fits({1'b0, oldest_completion_entry.cr_upd}, {1'b0, second_completion_entry.cr_upd},
        3'(`CR_LIMIT))
      & pair_fits(oldest_completion_entry.gpr_upd, second_completion_entry.gpr_upd,
        3'(`GPR_LIMIT))
      & pair_fits({1'b0, oldest_completion_entry.fpr_upd}, {1'b0, second_completion_entry.fpr_upd},
        3'(`FPR_LIMIT));
    second_ok = oldest_ok
      & entry_ready(second_completion_entry)
      & second_completion_entry.int_or_load
      & pair_ok;
  end

  // Oldest first, second only alongside it
  assign retire_oldest = oldest_ok;
  assign retire_second = second_ok;

  // Next state
  always_comb
  begin
    next_state = state;
    issued = `EXEC_CNT_W'(lower_ok) + `EXEC_CNT_W'(upper_ok);
    drain_sum = {1'b0, `EXEC_CNT_W'(exec_finish)};
    if (mispredict)
    begin
      drain_sum = drain_sum + {1'b0, squash_count};
    end
    // Saturate so a large squash cannot wrap
    drained = drain_sum[`EXEC_CNT_W] ? {`EXEC_CNT_W{1'b1}} : drain_sum[`EXEC_CNT_W-1:0];
    if (drained >= state.exec_count + issued)
    begin
      next_state.exec_count = '0;
    end
    else
    begin
      next_state.exec_count = state.exec_count + issued - drained;
    end
    // Illegal pulse for a valid arch64 lower slot while serial is idle and no mispredict
    next_state.illegal = lower_dispatch_slot.valid & lower_dispatch_slot.arch64
      & (state.ser == SER_IDLE) & ~mispredict;
    next_state.branch_done = resolve_ok;
    next_state.discard = mispredict;
    // Exception only for a finished, non-speculative oldest entry
    next_state.take_exception = oldest_completion_entry.valid & oldest_completion_entry.finished
      & oldest_completion_entry.exception & ~oldest_completion_entry.after_unresolved & ~mispredict;
    case (state.ser)
      SER_IDLE:
      begin
        // Count restarts for each serialized instruction
        next_state.ser_cycles = '0;
        if (lower_ok & lower_dispatch_slot.serial)
        begin
          next_state.ser = SER_BUSY;
        end
      end
      SER_BUSY:
      begin
        // Count stops at all ones rather than wrap
        if (state.ser_cycles != SER_SAT)
        begin
          next_state.ser_cycles = state.ser_cycles + `SER_CNT_W'(1);
        end
        // Busy until the far side signals the end
        if (ser_done)
        begin
          next_state.ser = SER_IDLE;
        end
      end
      default:
      begin
        next_state.ser = SER_IDLE;
        next_state.ser_cycles = '0;
      end
    endcase
  end

  // Pulses and counters register here
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state.ser <= SER_IDLE;
      state.exec_count <= '0;
      state.ser_cycles <= '0;
      state.illegal <= 1'b0;
      state.branch_done <= 1'b0;
      state.discard <= 1'b0;
      state.take_exception <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Registered outputs straight from state
  assign branch_folded = state.branch_done;
  assign discard_younger = state.discard;
  assign illegal_instr = state.illegal;
  assign take_exception = state.take_exception;
  assign serial_busy = (state.ser == SER_BUSY);
  assign serial_cycles = state.ser_cycles;
  assign exec_count = state.exec_count;

endmodule

//--- tb/far_side_model.sv
// Far side stand-in: execution units, rename pools and finishing work.
// Assumes the bench sets busy units, pool size and whether work drains.
`timescale 1ns/1ns
module far_side_model
(
  input wire logic [7:0] busy_mask,
  input wire logic [2:0] pool,
  input wire logic drain,
  output logic [7:0] unit_free,
  output logic [2:0] gpr_free,
  output logic [2:0] fpr_free,
  output logic [1:0] exec_finish
);
  assign unit_free = ~busy_mask;
  assign gpr_free = pool;
  assign fpr_free = pool;
  // Two finish per cycle while draining
  assign exec_finish = drain ? 2'h2 : 2'h0;
endmodule

//--- tb/dcc_asserts.sv
// Port checks for the dual dispatch and completion control.
// Assumes it is bound onto every dispatch_completion_control.
`timescale 1ns/1ns
module dcc_checks
  import dispatch_pkg::*;
#(
  parameter int EXEC_LIMIT = 5
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire dispatch_pkg::branch_t branch,
  input wire logic link_ready,
  input wire logic mispredict,
  input wire dispatch_pkg::slot_t lower_dispatch_slot,
  input wire dispatch_pkg::slot_t upper_dispatch_slot,
  input wire dispatch_pkg::centry_t oldest_completion_entry,
  input wire dispatch_pkg::centry_t second_completion_entry,
  input wire logic branch_resolve_now,
  input wire logic branch_folded,
  input wire logic dispatch_lower,
  input wire logic dispatch_upper,
  input wire logic retire_oldest,
  input wire logic retire_second,
  input wire logic discard_younger,
  input wire logic serial_busy,
  input wire logic [3:0] exec_count
);
  wire centry_t o = oldest_completion_entry;
  wire centry_t s = second_completion_entry;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_resolved;
    branch_resolve_now;
  endsequence
  sequence s_folded;
    branch_folded;
  endsequence
  chk_fold_next: assert property (s_resolved |=> s_folded)
    else $error("branch fold missing");
  chk_link_wait: assert property (branch.valid && branch.kind == BR_TO_LINK && !link_ready |->
    !branch_resolve_now) else $error("branch resolved early");
  chk_upper_pair: assert property (dispatch_upper |-> dispatch_lower && !lower_dispatch_slot.serial)
    else $error("upper issued alone");
  chk_upper_serial: assert property (dispatch_upper |-> !upper_dispatch_slot.serial)
    else $error("serial from upper");
  chk_serial_hold: assert property (serial_busy |-> !dispatch_lower && !dispatch_upper)
    else $error("issue while serial");
  chk_exec_cap: assert property (exec_count >= EXEC_LIMIT |-> !dispatch_lower)
    else $error("issue past limit");
  chk_oldest_ready: assert property (retire_oldest |-> o.finished && !o.after_unresolved && !o.exception)
    else $error("oldest retired early");
  chk_second_pair: assert property (retire_second |-> retire_oldest && s.int_or_load && s.finished &&
    !s.exception && !s.after_unresolved) else $error("second retired wrongly");
  chk_pair_limit: assert property (retire_second |-> o.cr_upd + s.cr_upd <= 1 &&
    o.gpr_upd + s.gpr_upd <= 2 && o.fpr_upd + s.fpr_upd <= 1) else $error("paired updates exceed");
  chk_mispredict_flush: assert property (mispredict |-> (!dispatch_lower && !retire_oldest)
    ##1 discard_younger) else $error("mispredict not flushed");
endmodule
bind dispatch_completion_control dcc_checks #(.EXEC_LIMIT(EXEC_LIMIT)) chk_i (.*);

//--- tb/testbench.sv
// Self-checking bench for the dual dispatch and completion control.
// Assumes far_side_model supplies units, rename pools and finishes.
`timescale 1ns/1ns
module testbench;
  import dispatch_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  branch_t branch = '0;
  logic link_ready = 0, count_ready = 0, shadow_free = 1, unresolved_pred = 0, mispredict = 0, ser_done = 0;
  logic drain = 1;
  slot_t lower_dispatch_slot = '0, upper_dispatch_slot = '0;
  centry_t oldest_completion_entry = '0, second_completion_entry = '0;
  logic [7:0] busy_mask = '0, unit_free, serial_cycles;
  logic [2:0] pool = 3'h4, gpr_free, fpr_free, cq_count = '0;
  logic [3:0] squash_count = '0, exec_count;
  logic [1:0] exec_finish;
  logic branch_resolve_now, branch_folded, dispatch_lower, dispatch_upper, retire_oldest, retire_second;
  logic discard_younger, illegal_instr, take_exception, serial_busy;
  int n_mismatch = 0, compares = 0, cyc = 0;
  dispatch_completion_control dut (.*);
  far_side_model far (.*);
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic final_report();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic slot_t sl(logic [2:0] u, logic [2:0] g, logic sr, logic a);
    return '{1'h1, u, g, 3'h1, sr, a};
  endfunction
  task automatic issue(slot_t lo, slot_t hi, logic [7:0] busy, logic [2:0] cq, logic el, logic eu);
    @(negedge clk);
    lower_dispatch_slot = lo;
    upper_dispatch_slot = hi;
    busy_mask = busy;
    cq_count = cq;
    #1 chk("dispatch", {dispatch_lower, dispatch_upper}, {el, eu});
  endtask
  task automatic ret(logic [7:0] o, logic [7:0] s, logic eo, logic es);
    @(negedge clk);
    oldest_completion_entry = {1'h1, o};
    second_completion_entry = {1'h1, s};
    #1 chk("retire", {retire_oldest, retire_second}, {eo, es});
  endtask
  task automatic t_branch();
    logic e;
    for (int k = 0; k < 12; k++)
    begin
      @(negedge clk);
      e = k < 5 ? k == 0 : k != 11;
      link_ready = k > 4 && k < 10;
      count_ready = k > 4 && k < 10;
      unresolved_pred = k < 5;
      shadow_free = k != 11;
      branch = '{1'h1, branch_kind_t'(k < 10 ? k % 5 : 33 - 3 * k), k == 11, k != 10};
      #1 chk("resolve", branch_resolve_now, e);
      @(posedge clk);
      #1 chk("fold", branch_folded, e);
    end
    @(negedge clk);
    branch = '0;
  endtask
  task automatic t_dual();
    issue(sl(0, 1, 0, 0), sl(1, 1, 0, 0), '0, '0, 1, 1);
    issue(sl(0, 1, 0, 0), sl(0, 1, 0, 0), '0, '0, 1, 0);
    issue(sl(0, 2, 0, 0), sl(1, 3, 0, 0), '0, '0, 1, 0);
    issue(sl(0, 1, 0, 0), sl(1, 1, 0, 0), '0, 3'h5, 1, 0);
    issue(sl(0, 1, 0, 0), sl(1, 1, 1, 0), '0, '0, 1, 0);
    issue(sl(0, 1, 0, 0), sl(1, 1, 0, 0), 8'h01, '0, 0, 0);
    issue(sl(0, 5, 0, 0), sl(1, 1, 0, 0), '0, '0, 0, 0);
    issue(sl(0, 1, 0, 0), '0, '0, 3'h6, 0, 0);
    issue(sl(0, 1, 0, 1), '0, '0, '0, 0, 0);
    @(posedge clk);
    #1 chk("illegal", illegal_instr, 1);
  endtask
  task automatic t_serial();
    issue(sl(2, 1, 1, 0), '0, '0, 3'h1, 0, 0);
    issue(sl(2, 1, 1, 0), sl(1, 1, 0, 0), '0, '0, 1, 0);
    issue(sl(0, 1, 0, 0), '0, '0, '0, 0, 0);
    chk("ser_cycles", serial_cycles, 0);
    chk("busy", serial_busy, 1);
    issue(sl(0, 1, 0, 0), '0, '0, '0, 0, 0);
    chk("ser_cycles", serial_cycles, 1);
    @(negedge clk);
    ser_done = 1;
    @(negedge clk);
    ser_done = 0;
    #1 chk("busy", serial_busy, 0);
    issue(sl(0, 1, 0, 0), '0, '0, '0, 1, 0);
  endtask
  task automatic t_retire();
    ret(8'h92, 8'h92, 1, 1);
    ret(8'h12, 8'h92, 0, 0);
    ret(8'hD2, 8'h92, 0, 0);
    ret(8'hB2, 8'h92, 0, 0);
    @(posedge clk);
    #1 chk("exception", take_exception, 1);
    ret(8'h92, 8'h82, 1, 0);
    ret(8'h92, 8'hD2, 1, 0);
    ret(8'h92, 8'hB2, 1, 0);
    ret(8'h92, 8'h12, 1, 0);
    ret(8'h9A, 8'h9A, 1, 0);
    ret(8'h94, 8'h92, 1, 0);
    ret(8'h94, 8'h90, 1, 1);
    ret(8'h93, 8'h93, 1, 0);
  endtask
  task automatic t_exec();
    issue('0, '0, '0, '0, 0, 0);
    drain = 0;
    repeat (5) issue(sl(0, 1, 0, 0), '0, '0, '0, 1, 0);
    issue(sl(0, 1, 0, 0), '0, '0, '0, 0, 0);
    chk("exec", exec_count, 5);
    @(negedge clk);
    mispredict = 1;
    squash_count = 4'h5;
    #1 chk("hold", {dispatch_lower, retire_oldest}, 0);
    @(posedge clk);
    #1 chk("discard", discard_younger, 1);
    chk("exec", exec_count, 0);
    @(negedge clk);
    mispredict = 0;
    #1 chk("resume", dispatch_lower, 1);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    t_branch();
    t_dual();
    t_serial();
    t_retire();
    t_exec();
    final_report();
  end
endmodule
